/* rtl/hbc_pkg.sv */
// Shared constants, types and helpers of the H-bridge control block
package hbc_pkg;

	// ====================================================================
	// Clock
	localparam int unsigned CLK_MHZ = 100;

	// ====================================================================
	// Register map: index per register, byte address is four times index
	localparam logic [9:0] REG_CTRL_IDX = 10'h000;
	localparam logic [9:0] REG_FAULT_IDX = 10'h001;
	localparam int unsigned IDX_LSB = 2;

	// Control register fields
	localparam int unsigned CTL_A_BIT = 0;
	localparam int unsigned CTL_B_BIT = 1;
	localparam int unsigned CODE_LSB = 2;
	localparam int unsigned CODE_W = 6;
	localparam logic [CODE_W-1:0] CODE_RST = 6'h00;

	// Fault register fields
	localparam int unsigned FLT_ERR_BIT = 0;
	localparam int unsigned FLT_OC_BIT = 1;
	localparam int unsigned FLT_UV_BIT = 2;
	localparam int unsigned FLT_OT_BIT = 3;
	localparam int unsigned FLT_LIM_BIT = 4;
	localparam int unsigned FLT_CLR_BIT = 7;

	// ====================================================================
	// Voltage target: gain times reference times (code + 1) over steps
	localparam int unsigned VREF_MV = 1285;
	localparam int unsigned VGAIN = 4;
	localparam int unsigned CODE_STEPS = 64;
	localparam int unsigned MV_W = 13;

	// ====================================================================
	// Timing
	localparam int unsigned LIM_DEGLITCH_NS = 3000;
	localparam int unsigned LIM_DEGLITCH_CYC = (LIM_DEGLITCH_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned LIM_FAULT_MS = 275;
	localparam int unsigned LIM_FAULT_CYC = LIM_FAULT_MS * CLK_MHZ * 1000;
	localparam int unsigned OC_TIME_NS = 1000;
	localparam int unsigned OC_TIME_CYC = (OC_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned SOFTSTART_MS = 12;
	localparam int unsigned DUTY_W = 8;
	localparam int unsigned RAMP_STEP_CYC = SOFTSTART_MS * CLK_MHZ * 1000 / (1 << DUTY_W);

	// ====================================================================
	// Bridge modes
	typedef enum logic [1:0] {MODE_COAST, MODE_REV, MODE_FWD, MODE_BRAKE} hbc_mode_e;

	// Decode the two control bits into a bridge mode
	function automatic hbc_mode_e hbc_decode(input logic a, input logic b);
		case ({a, b})
			2'b01: hbc_decode = MODE_REV;
			2'b10: hbc_decode = MODE_FWD;
			2'b11: hbc_decode = MODE_BRAKE;
			default: hbc_decode = MODE_COAST;
		endcase
	endfunction : hbc_decode

	// Target motor voltage in millivolts for a code
	function automatic logic [MV_W-1:0] hbc_target_mv(input logic [CODE_W-1:0] code);
		int unsigned v;
		v = VGAIN * VREF_MV * (int'(code) + 1) / CODE_STEPS;
		hbc_target_mv = v[MV_W-1:0];
	endfunction : hbc_target_mv

endpackage : hbc_pkg

/* rtl/hbc_sync.sv */
// Two-stage synchroniser for comparator inputs
`timescale 1ns/100ps
module hbc_sync
	import hbc_pkg::*;
#(
	parameter int unsigned W = 1
)(
	// Clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic clkEn,
	// Data
	input wire logic [W-1:0] asyncIn,
	output logic [W-1:0] syncOut
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} hbc_sync_s;

	hbc_sync_s state_q, state_d;

	if (W < 1)
	begin : g_chk
		$error("hbc_sync width must be at least one");
	end

	// First stage feeds only the second
	always_comb
	begin
		state_d = state_q;
		state_d.meta = asyncIn;
		state_d.stable = state_q.meta;
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			state_q <= '0;
		else if (clkEn)
			state_q <= state_d;
	end

	assign syncOut = state_q.stable;

endmodule : hbc_sync

/* rtl/hbc_pwm.sv */
// Free-running PWM generator with registered on and period-end outputs
`timescale 1ns/100ps
module hbc_pwm
	import hbc_pkg::*;
#(
	parameter int unsigned DW = DUTY_W
)(
	// Clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic clkEn,
	// Duty in, phase out
	input wire logic [DW-1:0] duty,
	output logic pwmOn,
	output logic periodEnd
);

	typedef struct packed {
		logic [DW-1:0] cnt;
		logic on;
		logic wrap;
	} hbc_pwm_s;

	hbc_pwm_s state_q, state_d;

	if (DW < 2 || DW > 16)
	begin : g_chk
		$error("hbc_pwm duty width out of range");
	end

	// Full-scale duty is held on through the whole period, so no off gap
	always_comb
	begin
		state_d = state_q;
		state_d.cnt = state_q.cnt + 1'b1;
		state_d.on = (&duty) || (state_q.cnt < duty);
		state_d.wrap = &state_q.cnt;
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			state_q <= '0;
		else if (clkEn)
			state_q <= state_d;
	end

	assign pwmOn = state_q.on;
	assign periodEnd = state_q.wrap;

endmodule : hbc_pwm

/* rtl/hbc_bridge_ctl.sv */
// H-bridge control, regulation, protection and AHB-Lite register slave
`timescale 1ns/100ps
module hbc_bridge_ctl
	import hbc_pkg::*;
#(
	parameter int unsigned FAULT_CYC = LIM_FAULT_CYC,
	parameter int unsigned RAMP_CYC = RAMP_STEP_CYC
)(
	// Clock, reset and clock enable
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic clkEn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Analog comparator inputs, asynchronous
	input wire logic senseOverLimit,
	input wire logic [1:0] ocHighSide,
	input wire logic [1:0] ocLowSide,
	input wire logic overTemp,
	input wire logic lowSupply,
	input wire logic avgBelowTarget,
	input wire logic supplyBelowTarget,
	// Bridge gate drive, index 0 is out1, 1 is out2
	output logic [1:0] hiSideOn,
	output logic [1:0] loSideOn,
	// Status pins
	output logic sleepMode,
	output logic [MV_W-1:0] targetMv,
	output logic errorOutN
);

	// ====================================================================
	// Widths and checks
	localparam int unsigned FT_W = $clog2(FAULT_CYC + 1);
	localparam int unsigned RC_W = $clog2(RAMP_CYC + 1);
	localparam int unsigned DG_W = $clog2(LIM_DEGLITCH_CYC + 1);
	localparam int unsigned OC_W = $clog2(OC_TIME_CYC + 1);
	localparam logic [DUTY_W-1:0] DUTY_FULL = '1;

	if (FAULT_CYC < 2 || RAMP_CYC < 1 || FT_W > 32)
	begin : g_chk
		$error("hbc_bridge_ctl timing parameters out of range");
	end

	typedef struct packed {
		logic [CODE_W-1:0] code;
		logic ctlA;
		logic ctlB;
		logic limF;
		logic ocF;
		logic otF;
		logic uvF;
		logic [DG_W-1:0] dglCnt;
		logic limActive;
		logic [FT_W-1:0] faultCnt;
		logic [OC_W-1:0] ocCnt;
		logic [DUTY_W-1:0] duty;
		logic [DUTY_W-1:0] rampCap;
		logic [RC_W-1:0] rampCnt;
		logic dpWr;
		logic [9:0] dpIdx;
		logic [31:0] rdata;
		logic [1:0] hs;
		logic [1:0] ls;
		logic [MV_W-1:0] target;
		logic errN;
	} hbc_state_s;

	hbc_state_s state_q, state_d;

	// ====================================================================
	// Comparator synchronisers and PWM
	logic [8:0] syncIn;
	logic [8:0] syncOut;
	logic sense, otNow, uvNow, avgLow, supLow;
	logic [1:0] ocHs, ocLs;
	logic pwmOn, periodEnd;
	logic [DUTY_W-1:0] dutyEff;

	assign syncIn = {senseOverLimit, ocHighSide, ocLowSide, overTemp, lowSupply,
		avgBelowTarget, supplyBelowTarget};

	hbc_sync #(.W(9)) u_sync (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.clkEn(clkEn),
		.asyncIn(syncIn),
		.syncOut(syncOut)
	);

	assign {sense, ocHs, ocLs, otNow, uvNow, avgLow, supLow} = syncOut;

	// Ramp cap bounds duty; low supply skips the regulator unless limiting
	assign dutyEff = (supLow && !state_q.limActive) ? state_q.rampCap :
		((state_q.duty < state_q.rampCap) ? state_q.duty : state_q.rampCap);

	hbc_pwm #(.DW(DUTY_W)) u_pwm (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.clkEn(clkEn),
		.duty(dutyEff),
		.pwmOn(pwmOn),
		.periodEnd(periodEnd)
	);

	// ====================================================================
	// Next state
	hbc_mode_e modeNow, modeNew;
	logic addrPhase, driving, disabled, errNow;

	assign addrPhase = hsel && hready && htrans[1];
	assign modeNow = hbc_decode(state_q.ctlA, state_q.ctlB);

	always_comb
	begin
		state_d = state_q;
		modeNew = modeNow;
		// Bus address phase: latch write intent, capture read data now
		state_d.dpWr = addrPhase && hwrite;
		state_d.dpIdx = haddr[IDX_LSB +: 10];
		state_d.rdata = '0;
		if (addrPhase && !hwrite)
		begin
			case (haddr[IDX_LSB +: 10])
				REG_CTRL_IDX:
				begin
					state_d.rdata[CODE_LSB +: CODE_W] = state_q.code;
					state_d.rdata[CTL_A_BIT] = state_q.ctlA;
					state_d.rdata[CTL_B_BIT] = state_q.ctlB;
				end
				REG_FAULT_IDX:
				begin
					state_d.rdata[FLT_ERR_BIT] = errNow;
					state_d.rdata[FLT_OC_BIT] = state_q.ocF;
					state_d.rdata[FLT_UV_BIT] = state_q.uvF;
					state_d.rdata[FLT_OT_BIT] = state_q.otF;
					state_d.rdata[FLT_LIM_BIT] = state_q.limF;
				end
				default: state_d.rdata = '0;
			endcase
		end
		// Data phase writes; clears come first so that new events win
		if (state_q.dpWr)
		begin
			case (state_q.dpIdx)
				REG_CTRL_IDX:
				begin
					state_d.code = hwdata[CODE_LSB +: CODE_W];
					state_d.ctlA = hwdata[CTL_A_BIT];
					state_d.ctlB = hwdata[CTL_B_BIT];
					modeNew = hbc_decode(hwdata[CTL_A_BIT], hwdata[CTL_B_BIT]);
					if (hwdata[CTL_A_BIT] == hwdata[CTL_B_BIT])
					begin
						state_d.limF = 1'b0;
						state_d.faultCnt = '0;
					end
					if ((modeNow == MODE_COAST || modeNow == MODE_BRAKE) &&
						(modeNew == MODE_FWD || modeNew == MODE_REV))
					begin
						state_d.duty = '0;
						state_d.rampCap = '0;
						state_d.rampCnt = '0;
					end
				end
				REG_FAULT_IDX:
				begin
					if (hwdata[FLT_CLR_BIT])
					begin
						state_d.limF = 1'b0;
						state_d.ocF = 1'b0;
						state_d.otF = 1'b0;
						state_d.uvF = 1'b0;
					end
				end
				default: ;
			endcase
		end
		// Current-limit deglitch restarts whenever the sense drops
		if (sense && modeNow != MODE_COAST)
		begin
			if (state_q.dglCnt == DG_W'(LIM_DEGLITCH_CYC - 1))
				state_d.limActive = 1'b1;
			else
				state_d.dglCnt = state_q.dglCnt + 1'b1;
		end
		else
		begin
			state_d.dglCnt = '0;
			state_d.limActive = 1'b0;
		end
		// Sustained-limit timer; the bridge keeps running after it fires
		if (state_q.limActive && modeNow != MODE_COAST)
		begin
			if (state_q.faultCnt == FT_W'(FAULT_CYC - 1))
				state_d.limF = 1'b1;
			else
				state_d.faultCnt = state_q.faultCnt + 1'b1;
		end
		else if (!state_q.dpWr || state_q.dpIdx != REG_CTRL_IDX)
			state_d.faultCnt = '0;
		// Sleep drops any pending limit fault
		if (modeNow == MODE_COAST && !state_q.dpWr)
		begin
			state_d.limF = 1'b0;
			state_d.faultCnt = '0;
		end
		// Overcurrent on any single transistor, either side, latches
		if ((|ocHs) || (|ocLs))
		begin
			if (state_q.ocCnt == OC_W'(OC_TIME_CYC - 1))
				state_d.ocF = 1'b1;
			else
				state_d.ocCnt = state_q.ocCnt + 1'b1;
		end
		else
			state_d.ocCnt = '0;
		// Thermal and supply flags stick until cleared
		if (otNow)
			state_d.otF = 1'b1;
		if (uvNow)
			state_d.uvF = 1'b1;
		// Soft-start ramp raises the duty cap one step per interval
		if (driving)
		begin
			if (state_q.rampCnt >= RC_W'(RAMP_CYC - 1))
			begin
				state_d.rampCnt = '0;
				if (state_q.rampCap != DUTY_FULL)
					state_d.rampCap = state_q.rampCap + 1'b1;
			end
			else
				state_d.rampCnt = state_q.rampCnt + 1'b1;
		end
		else if (!state_q.dpWr)
			state_d.rampCnt = '0;
		// Regulator steps once per PWM period; limit chopping wins
		if (driving && periodEnd && !(state_q.dpWr && state_q.dpIdx == REG_CTRL_IDX))
		begin
			if (state_q.limActive)
			begin
				if (state_q.duty != '0)
					state_d.duty = state_q.duty - 1'b1;
			end
			else if (supLow)
				state_d.duty = DUTY_FULL;
			else if (avgLow)
			begin
				if (state_q.duty != DUTY_FULL)
					state_d.duty = state_q.duty + 1'b1;
			end
			else if (state_q.duty != '0)
				state_d.duty = state_q.duty - 1'b1;
		end
		// Gate drive; off time recirculates through both high sides
		case (modeNow)
			MODE_FWD:
			begin
				state_d.hs = pwmOn ? 2'b01 : 2'b11;
				state_d.ls = pwmOn ? 2'b10 : 2'b00;
			end
			MODE_REV:
			begin
				state_d.hs = pwmOn ? 2'b10 : 2'b11;
				state_d.ls = pwmOn ? 2'b01 : 2'b00;
			end
			MODE_BRAKE:
			begin
				state_d.hs = 2'b11;
				state_d.ls = 2'b00;
			end
			default:
			begin
				state_d.hs = 2'b00;
				state_d.ls = 2'b00;
			end
		endcase
		// Hard faults override; thermal and supply release on recovery
		if (disabled)
		begin
			state_d.hs = 2'b00;
			state_d.ls = 2'b00;
		end
		state_d.target = hbc_target_mv(state_q.code);
		state_d.errN = !errNow;
	end

	// Only forward and reverse use the regulator and ramp
	assign driving = (modeNow == MODE_FWD || modeNow == MODE_REV) && !disabled;
	assign disabled = state_q.ocF || otNow || uvNow;
	assign errNow = state_q.limF || disabled;

	// ====================================================================
	// State register; reset lands in sleep with the bridge off
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= '0;
			state_q.code <= CODE_RST;
			state_q.errN <= 1'b1;
		end
		else if (clkEn)
			state_q <= state_d;
	end

	// ====================================================================
	// Outputs
	assign hreadyout = 1'b1; // Zero wait states
	assign hresp = 1'b0;
	assign hrdata = state_q.rdata;
	assign hiSideOn = state_q.hs;
	assign loSideOn = state_q.ls;
	assign sleepMode = !(state_q.ctlA || state_q.ctlB);
	assign targetMv = state_q.target;
	assign errorOutN = state_q.errN;

endmodule : hbc_bridge_ctl

/* test/hbc_chk.sv */
// Concurrent checks on the ports of the H-bridge control block
`timescale 1ns/100ps
module hbc_chk
(
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic clkEn,
	// Register bus
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	// Comparators
	input wire logic [1:0] ocHighSide,
	input wire logic [1:0] ocLowSide,
	input wire logic overTemp,
	input wire logic lowSupply,
	// Bridge and status
	input wire logic [1:0] hiSideOn,
	input wire logic [1:0] loSideOn,
	input wire logic sleepMode,
	input wire logic errorOutN
);
	// ====================================================================
	// Helper
	logic [7:0] ocCnt_q;

	// Run length of any overcurrent input, saturating so it never wraps
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			ocCnt_q <= 8'h00;
		else if (!clkEn || (ocHighSide == 2'b00 && ocLowSide == 2'b00))
			ocCnt_q <= 8'h00;
		else if (ocCnt_q != 8'hff)
			ocCnt_q <= ocCnt_q + 8'h01;
	end

	// ====================================================================
	// Properties
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	// Five samples cover the two sync flops plus the output register
	sequence hotSeen; (overTemp && clkEn)[*5]; endsequence
	sequence lowSeen; (lowSupply && clkEn)[*5]; endsequence
	sequence asleep; sleepMode[*4]; endsequence
	property bridgeDown(s);
		s |-> hiSideOn == 2'b00 && loSideOn == 2'b00 && !errorOutN;
	endproperty

	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus slave stalled or answered with an error");
	chk_rdata_idle: assert property (!$past(hsel && hready && htrans[1] && clkEn)
		|-> hrdata == 32'h0000_0000) else $error("read data outside a data phase");
	chk_sleep_off: assert property (asleep |-> hiSideOn == 2'b00 && loSideOn == 2'b00)
		else $error("gates on while asleep");
	chk_no_shoot: assert property ((hiSideOn & loSideOn) == 2'b00)
		else $error("both transistors of one leg on");
	chk_hot_off: assert property (bridgeDown(hotSeen))
		else $error("bridge still driven when hot");
	chk_low_off: assert property (bridgeDown(lowSeen))
		else $error("bridge still driven on low supply");
	chk_oc_off: assert property (ocCnt_q >= 8'h6a |-> hiSideOn == 2'b00 && loSideOn == 2'b00
		&& !errorOutN) else $error("bridge still driven after overcurrent");
	chk_power_up: assert property ($rose(arst_n) |-> sleepMode && errorOutN
		&& hiSideOn == 2'b00 && loSideOn == 2'b00) else $error("not asleep after reset");
endmodule : hbc_chk

bind hbc_bridge_ctl hbc_chk u_chk(.core_clk, .arst_n, .clkEn, .hsel, .htrans, .hready,
	.hreadyout, .hresp, .hrdata, .ocHighSide, .ocLowSide, .overTemp, .lowSupply,
	.hiSideOn, .loSideOn, .sleepMode, .errorOutN);

/* test/hbc_host.sv */
// Host model: single-word AHB-Lite master
`timescale 1ns/100ps
module hbc_host
(
	// Clock and answer
	input wire logic core_clk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	// Request
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	// Idle bus at time zero
	initial
	begin
		{hsel, haddr, htrans, hwrite, hwdata} = '0;
		hsize = 3'h2;
	end

	// One transfer; the leading edge keeps two calls out of one time step
	task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] rd);
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge core_clk);
		while (!hready) @(posedge core_clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge core_clk);
		while (!hready) @(posedge core_clk);
		rd = hrdata;
		hsel <= 1'b0;
		haddr <= ~a;
		hwdata <= ~d;
	endtask : xfer
endmodule : hbc_host

/* test/tb_hbridge_control_and_fault_logic.sv */
// Self-checking bench of the H-bridge control block
`timescale 1ns/100ps
module tb_hbridge_control_and_fault_logic;
	import hbc_pkg::*;
	localparam int unsigned FLT = 500;
	logic core_clk, arst_n, clkEn, hsel, hwrite, hreadyout, hresp, senseOverLimit, overTemp;
	logic lowSupply, avgBelowTarget, supplyBelowTarget, sleepMode, errorOutN;
	logic [31:0] haddr, hwdata, hrdata, rd, seed;
	logic [1:0] htrans, ocHighSide, ocLowSide, hiSideOn, loSideOn;
	logic [2:0] hsize;
	logic [5:0] c;
	logic [MV_W-1:0] targetMv;
	logic [1:0] modes [4] = '{2'h1, 2'h2, 2'h3, 2'h1};
	int nFail = 0, nChecks = 0, sOn, sBad, cyc = 0;

	// ====================================================================
	// Instances
	hbc_bridge_ctl #(.FAULT_CYC(FLT), .RAMP_CYC(4)) u_dut(.core_clk, .arst_n, .clkEn, .hsel,
		.haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
		.hrdata, .senseOverLimit, .ocHighSide, .ocLowSide, .overTemp, .lowSupply,
		.avgBelowTarget, .supplyBelowTarget, .hiSideOn, .loSideOn, .sleepMode, .targetMv,
		.errorOutN);
	hbc_host u_host(.core_clk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata);

	// Clock and hang guard
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			nFail++;
			tally_and_finish();
		end
	end

	// ====================================================================
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return x[31] ? (x << 1) ^ 32'h04c1_1db7 : x << 1;
	endfunction : lfsr

	// Gate pattern while the PWM is on; brake only ever shows recirculation
	function automatic logic [3:0] onPat(input logic [1:0] m);
		return m == 2'h1 ? 4'h6 : m == 2'h2 ? 4'h9 : 4'hc;
	endfunction : onPat

	task automatic chk(input string nm, input logic [31:0] e, g);
		nChecks++;
		if (g !== e)
		begin
			nFail++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [31:0] a, d);
		u_host.xfer(1'b1, a, d, rd);
	endtask : wr

	task automatic rdc(input string nm, input logic [31:0] a, e);
		u_host.xfer(1'b0, a, 32'h0000_0000, rd);
		chk(nm, e, rd);
	endtask : rdc

	// Count on-pattern cycles and cycles that are neither on nor off
	task automatic scan(input int n, input logic [3:0] pat);
		logic [3:0] g;
		sOn = 0;
		sBad = 0;
		repeat (n)
		begin
			@(posedge core_clk);
			g = {hiSideOn, loSideOn};
			if (g === pat && pat !== 4'hc) sOn++;
			else if (g !== 4'hc && g !== pat) sBad++;
		end
	endtask : scan

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", nChecks, nFail);
		if (nFail == 0 && nChecks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish

	// ====================================================================
	// Main sequence
	initial
	begin
		{arst_n, senseOverLimit, overTemp, lowSupply, ocHighSide, ocLowSide} = '0;
		{clkEn, avgBelowTarget, supplyBelowTarget} = 3'h6;
		seed = 32'hc88a_16f2;
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk("gates", 0, {hiSideOn, loSideOn});
		chk("sleep", 1, sleepMode);
		rdc("ctrl", 32'h0, 0);
		rdc("fault", 32'h4, 0);
		wr(32'h40, 32'hffff_ffff);
		rdc("unmapped", 32'h40, 0);
		for (int i = 0; i < 10; i++)
		begin
			c = i == 0 ? 6'h00 : i == 1 ? 6'h3f : seed[5:0];
			seed = lfsr(seed);
			wr(32'h0, {c, 2'h0});
			rdc("ctrl", 32'h0, {c, 2'h0});
			chk("target", VGAIN * VREF_MV * (c + 1) / CODE_STEPS, targetMv);
		end
		for (int k = 0; k < 4; k++)
		begin
			if (k == 1 || k == 2) wr(32'h0, 32'h0);
			wr(32'h0, {6'h3f, modes[k]});
			repeat (3) @(posedge core_clk);
			chk("awake", 0, sleepMode);
			scan(20, onPat(modes[k]));
			chk("ramp start", 0, sOn);
			chk("pattern", 0, sBad);
			scan(1200, onPat(modes[k]));
			chk("pattern", 0, sBad);
			chk("duty rises", modes[k] != 2'h3, sOn > 0);
			if (k == 3)
			begin
				avgBelowTarget <= 1'b0;
				repeat (1600) @(posedge core_clk);
				scan(300, onPat(modes[k]));
				chk("duty falls", 0, sOn);
				avgBelowTarget <= 1'b1;
			end
		end
		wr(32'h0, 32'h0);
		repeat (3) @(posedge core_clk);
		chk("coast gates", 0, {hiSideOn, loSideOn});
		chk("sleep", 1, sleepMode);
		wr(32'h0, 32'hfd);
		supplyBelowTarget <= 1'b1;
		repeat (1500) @(posedge core_clk);
		scan(300, 4'h6);
		chk("full duty", 1, sOn >= 298 && sBad == 0);
		for (int i = 0; i < 4; i++)
		begin
			{ocHighSide, ocLowSide} <= 4'h1 << i;
			repeat (150) @(posedge core_clk);
			{ocHighSide, ocLowSide} <= 4'h0;
			repeat (60) @(posedge core_clk);
			chk("oc gates", 0, {hiSideOn, loSideOn});
			chk("oc pin", 0, errorOutN);
			rdc("oc flags", 32'h4, 32'h3);
			wr(32'h4, 32'h80);
			repeat (4) @(posedge core_clk);
			rdc("cleared", 32'h4, 0);
			chk("oc pin", 1, errorOutN);
			chk("resumed", 1, |{hiSideOn, loSideOn});
		end
		for (int j = 0; j < 2; j++)
		begin
			{overTemp, lowSupply} <= j ? 2'h2 : 2'h1;
			repeat (10) @(posedge core_clk);
			chk("fault gates", 0, {hiSideOn, loSideOn});
			chk("fault pin", 0, errorOutN);
			rdc("flags", 32'h4, j ? 32'h9 : 32'h5);
			{overTemp, lowSupply} <= 2'h0;
			repeat (6) @(posedge core_clk);
			chk("recovered", 1, |{hiSideOn, loSideOn});
			chk("fault pin", 1, errorOutN);
			wr(32'h4, 32'h80);
		end
		// A frozen block must not see a hot die that comes and goes
		clkEn <= 1'b0;
		overTemp <= 1'b1;
		repeat (10) @(posedge core_clk);
		chk("frozen gates", 4'h6, {hiSideOn, loSideOn});
		chk("frozen pin", 1, errorOutN);
		{clkEn, overTemp} <= 2'h2;
		repeat (4) @(posedge core_clk);
		rdc("frozen flags", 32'h4, 0);
		repeat (4)
		begin
			senseOverLimit <= 1'b1;
			repeat (250) @(posedge core_clk);
			senseOverLimit <= 1'b0;
			repeat (5) @(posedge core_clk);
		end
		rdc("no limit", 32'h4, 0);
		for (int k = 0; k < 3; k++)
		begin
			wr(32'h0, 32'hfd);
			senseOverLimit <= 1'b1;
			repeat (300 + FLT + 60) @(posedge core_clk);
			chk("limit pin", 0, errorOutN);
			chk("still driving", 1, |{hiSideOn, loSideOn});
			senseOverLimit <= 1'b0;
			rdc("limit flags", 32'h4, 32'h11);
			if (k == 0) wr(32'h4, 32'h80);
			else wr(32'h0, k == 1 ? 32'hff : 32'h0);
			rdc("limit cleared", 32'h4, 0);
			chk("limit pin", 1, errorOutN);
		end
		// Both latched faults, then a power cycle in mid-run
		wr(32'h0, 32'hfd);
		senseOverLimit <= 1'b1;
		{ocHighSide, ocLowSide} <= 4'h8;
		repeat (300 + FLT + 60) @(posedge core_clk);
		{senseOverLimit, ocHighSide, ocLowSide} <= 5'h00;
		rdc("both flags", 32'h4, 32'h13);
		arst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		rdc("power cycle", 32'h4, 0);
		chk("power cycle", 3, {errorOutN, sleepMode});
		tally_and_finish();
	end
endmodule : tb_hbridge_control_and_fault_logic
